// >>> design/display_coupler_keyboard_channels.sv
// Control and status channel decode for the display unit coupler
//
// Operation
// - Control bit 6 selects character-compare termination for block transfers.
// - Control bit 7 selects bit-compare termination for block transfers.
// - Control bit 8 selects double-compare termination for block transfers.
// - Setting control bit 9 with select data (bit 3) set loads data output word into group 2/3 register.
// - Each keyboard output register bit drives one lamp or buzzer.
// - Setting control bit A with select data (bit 3) set loads data output word into group 0/1 register.
// - Status bits 2..5 report the selected keyboard's mode switches, zero is on.
// - Status bit 6 reports the selected alert switch, zero is on.
// - Status bit 7 is zero while repeat key is held, no data attached.
// - Status bit 8 zero means function code, one means ASCII character.
// - Status bits 9 upward carry the selected keyboard's key code.
// - Double compare, armed by a 1C or 1F data output character, ends transfer on either 1C or 1F in the stream.
`timescale 1ns/1ns
`default_nettype none

module display_coupler_keyboard_channels
   import display_coupler_pkg::*;
(
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic [WORD_W-1:0] coupler_control_word_in,
   input wire logic [WORD_W-1:0] data_output_word_in,
   input wire logic [WORD_W-1:0] xfer_word_in,
   input wire logic xfer_valid_in,
   input wire kb_pins_type kb_pins_in [NUM_KB],
   output logic [WORD_W-1:0] keyboard_status_word_out,
   output logic [WORD_W-1:0] kb_lamp_01_out,
   output logic [WORD_W-1:0] kb_lamp_23_out,
   output term_mode_type term_mode_out,
   output logic terminate_out
);

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   ////////////////////////////////////////////////////////////////////////
   // Control word decode

   logic strobe23_d_r;
   logic strobe01_d_r;
   logic strobe23_rise;
   logic strobe01_rise;
   logic sel_nc_data;
   logic lockout;
   logic [KSEL_W-1:0] kb_sel;
   term_mode_type mode_nxt;

   assign sel_nc_data = coupler_control_word_in[CTL_SEL_NC_DATA_BIT];
   assign lockout = coupler_control_word_in[CTL_LOCKOUT_BIT];
   assign kb_sel = coupler_control_word_in[CTL_KB_SEL_LSB +: KSEL_W];
   assign mode_nxt.char_cmp = coupler_control_word_in[CTL_CHAR_CMP_BIT];
   assign mode_nxt.bit_cmp = coupler_control_word_in[CTL_BIT_CMP_BIT];
   assign mode_nxt.double_cmp = coupler_control_word_in[CTL_DOUBLE_CMP_BIT];

   // Strobes act on the setting edge only; holding them set does nothing more
   assign strobe23_rise = coupler_control_word_in[CTL_STROBE_KB23_BIT] && !strobe23_d_r;
   assign strobe01_rise = coupler_control_word_in[CTL_STROBE_KB01_BIT] && !strobe01_d_r;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         strobe23_d_r <= 1'b0;
         strobe01_d_r <= 1'b0;
      end else if (clk_en_in) begin
         strobe23_d_r <= coupler_control_word_in[CTL_STROBE_KB23_BIT];
         strobe01_d_r <= coupler_control_word_in[CTL_STROBE_KB01_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Keyboard output registers

   // Data path to the registers exists only with select data set
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         kb_lamp_23_out <= LAMP_RESET;
      end else if (clk_en_in && strobe23_rise && sel_nc_data) begin
         kb_lamp_23_out <= data_output_word_in;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         kb_lamp_01_out <= LAMP_RESET;
      end else if (clk_en_in && strobe01_rise && sel_nc_data) begin
         kb_lamp_01_out <= data_output_word_in;
      end
   end

   sequence s_strobe01;
      clk_en_in && sel_nc_data && strobe01_rise;
   endsequence

   sequence s_strobe23;
      clk_en_in && sel_nc_data && strobe23_rise;
   endsequence

   a_lamp01_load: assert property (s_strobe01 |=> kb_lamp_01_out == $past(data_output_word_in))
      else $error("group 0/1 register missed its load");
   a_lamp23_load: assert property (s_strobe23 |=> kb_lamp_23_out == $past(data_output_word_in))
      else $error("group 2/3 register missed its load");
   a_lamp_hold: assert property (!(clk_en_in && sel_nc_data && strobe01_rise)
         |=> $stable(kb_lamp_01_out))
      else $error("group 0/1 register changed without a strobe");
   a_strobe_once: assert property (s_strobe23 ##1 (clk_en_in && sel_nc_data
         && coupler_control_word_in[CTL_STROBE_KB23_BIT]) |=> $stable(kb_lamp_23_out))
      else $error("held strobe reloaded group 2/3 register");

   ////////////////////////////////////////////////////////////////////////
   // Keyboard pin synchronisers and status word

   kb_pins_type kb_meta_r [NUM_KB];
   kb_pins_type kb_sync_r [NUM_KB];
   logic [WORD_W-1:0] status_nxt;

   // Pins idle high so a keyboard reads all switches off out of reset
   for (genvar k = 0; k < NUM_KB; k++) begin : g_kb_sync
      always_ff @(posedge mclk_in or posedge reset_in) begin
         if (reset_in) begin
            kb_meta_r[k] <= STATUS_IDLE[WORD_W-1:STAT_MODE_LSB];
            kb_sync_r[k] <= STATUS_IDLE[WORD_W-1:STAT_MODE_LSB];
         end else if (clk_en_in) begin
            kb_meta_r[k] <= kb_pins_in[k];
            kb_sync_r[k] <= kb_meta_r[k];
         end
      end
   end

   // Unfitted keyboard codes read as an idle keyboard
   always_comb begin
      status_nxt = STATUS_IDLE;
      if (kb_sel < KSEL_W'(NUM_KB)) begin
         status_nxt = {kb_sync_r[kb_sel[1:0]], STATUS_LOW_ZERO};
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         keyboard_status_word_out <= STATUS_RESET;
      end else if (clk_en_in) begin
         keyboard_status_word_out <= status_nxt;
      end
   end

   a_status_select: assert property (clk_en_in && kb_sel < KSEL_W'(NUM_KB) |=>
         keyboard_status_word_out[WORD_W-1:STAT_MODE_LSB] == $past(kb_sync_r[kb_sel[1:0]]))
      else $error("status word does not follow the selected keyboard");
   a_status_fields: assert property (clk_en_in && kb_sel < KSEL_W'(NUM_KB) |=>
         keyboard_status_word_out[STAT_REPEAT_BIT] == $past(kb_sync_r[kb_sel[1:0]].repeat_n)
         && keyboard_status_word_out[STAT_FUNC_BIT] == $past(kb_sync_r[kb_sel[1:0]].func_strobe_n)
         && keyboard_status_word_out[STAT_ALERT_BIT] == $past(kb_sync_r[kb_sel[1:0]].alert_n))
      else $error("status flag bits misplaced");
   a_status_unfit: assert property (clk_en_in && kb_sel >= KSEL_W'(NUM_KB) |=>
         keyboard_status_word_out == STATUS_IDLE)
      else $error("unfitted keyboard does not read idle");

   ////////////////////////////////////////////////////////////////////////
   // Block transfer terminating conditions

   logic [6:0] cmp_char;
   logic char_hit;
   logic bit_hit;
   logic double_hit;
   logic double_armed;
   logic term_nxt;

   assign cmp_char = data_output_word_in[6:0];
   assign char_hit = xfer_word_in[6:0] == cmp_char || xfer_word_in[14:8] == cmp_char;
   // Bit compare: any stream bit that is also set in the data output word
   assign bit_hit = |(xfer_word_in & data_output_word_in);
   assign double_armed = cmp_char == END_FILE_CODE || cmp_char == END_RECORD_CODE;
   assign double_hit = double_armed &&
      (xfer_word_in[6:0] == END_FILE_CODE || xfer_word_in[6:0] == END_RECORD_CODE ||
       xfer_word_in[14:8] == END_FILE_CODE || xfer_word_in[14:8] == END_RECORD_CODE);
   assign term_nxt = xfer_valid_in && !lockout &&
      ((mode_nxt.char_cmp && char_hit) ||
       (mode_nxt.bit_cmp && bit_hit) ||
       (mode_nxt.double_cmp && double_hit));

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         terminate_out <= 1'b0;
      end else if (clk_en_in) begin
         terminate_out <= term_nxt;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         term_mode_out <= TERM_MODE_RESET;
      end else if (clk_en_in) begin
         term_mode_out <= mode_nxt;
      end
   end

   sequence s_active_xfer;
      clk_en_in && xfer_valid_in && !lockout;
   endsequence

   a_char_term: assert property (s_active_xfer and (mode_nxt.char_cmp && char_hit)
         |=> terminate_out)
      else $error("character compare hit did not terminate");
   a_bit_term: assert property (s_active_xfer and (mode_nxt.bit_cmp && bit_hit)
         |=> terminate_out)
      else $error("bit compare hit did not terminate");
   a_double_term: assert property (s_active_xfer and (mode_nxt.double_cmp && double_armed
         && xfer_word_in[6:0] == END_RECORD_CODE) |=> terminate_out)
      else $error("double compare code did not terminate");
   a_no_mode_quiet: assert property (clk_en_in && (lockout || !xfer_valid_in
         || mode_nxt == TERM_MODE_RESET) |=> !terminate_out)
      else $error("terminate without a selected live condition");

endmodule : display_coupler_keyboard_channels

`default_nettype wire

// >>> design/display_coupler_pkg.sv
// Constants and types for the display coupler keyboard channel block
package display_coupler_pkg;

   localparam int WORD_W = 16;
   localparam int NUM_KB = 4;
   localparam int KSEL_W = 5;

   // Control word bit positions
   localparam int CTL_LOCKOUT_BIT = 2;
   localparam int CTL_SEL_NC_DATA_BIT = 3;
   localparam int CTL_CHAR_CMP_BIT = 6;
   localparam int CTL_BIT_CMP_BIT = 7;
   localparam int CTL_DOUBLE_CMP_BIT = 8;
   localparam int CTL_STROBE_KB23_BIT = 9;
   localparam int CTL_STROBE_KB01_BIT = 10;
   localparam int CTL_KB_SEL_LSB = 11;

   // Status word field positions
   localparam int STAT_MODE_LSB = 2;
   localparam int STAT_ALERT_BIT = 6;
   localparam int STAT_REPEAT_BIT = 7;
   localparam int STAT_FUNC_BIT = 8;
   localparam int STAT_DATA_LSB = 9;

   // Double compare codes
   localparam logic [6:0] END_FILE_CODE = 7'h1C;
   localparam logic [6:0] END_RECORD_CODE = 7'h1F;

   // Values after reset; status idles with every switch off
   localparam logic [WORD_W-1:0] LAMP_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] STATUS_RESET = 16'hFFFC;
   localparam logic [WORD_W-1:0] STATUS_IDLE = 16'hFFFC;
   localparam logic [1:0] STATUS_LOW_ZERO = 2'h0;

   // Keyboard pin group, all active low, laid out as status bits F..2
   typedef struct packed {
      logic [6:0] key_data_n;
      logic func_strobe_n;
      logic repeat_n;
      logic alert_n;
      logic [3:0] mode_n;
   } kb_pins_type;

   // Selected terminating conditions
   typedef struct packed {
      logic double_cmp;
      logic bit_cmp;
      logic char_cmp;
   } term_mode_type;

   localparam term_mode_type TERM_MODE_RESET = 3'h0;

endpackage : display_coupler_pkg

// >>> bench/kb_model.sv
// Keyboard pin model: four keyboards with active low lines
`timescale 1ns/1ns
`default_nettype none

module kb_model
   import display_coupler_pkg::*;
(
   output var kb_pins_type pins_out [NUM_KB]
);

   // Pull-ups hold every released line high
   initial begin
      for (int i = 0; i < NUM_KB; i++) begin
         pins_out[i] = 14'h3FFF;
      end
   end

   task automatic set_pins(input int k, input kb_pins_type v);
      pins_out[k] = v;
   endtask : set_pins

endmodule : kb_model

`default_nettype wire

// >>> bench/tb_display_coupler_keyboard_channels.sv
// Self-checking bench for the keyboard channel decode
`timescale 1ns/1ns
`default_nettype none

module tb_display_coupler_keyboard_channels;
   import display_coupler_pkg::*;

   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic ce = 1'b1;
   logic [WORD_W-1:0] ctl = 16'h0000;
   logic [WORD_W-1:0] dout = 16'h0000;
   logic [WORD_W-1:0] xw = 16'h0000;
   logic xv = 1'b0;
   kb_pins_type kb_pins [NUM_KB];
   logic [WORD_W-1:0] status;
   logic [WORD_W-1:0] lamp01;
   logic [WORD_W-1:0] lamp23;
   term_mode_type tm;
   logic term;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;

   display_coupler_keyboard_channels i_dut (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .clk_en_in(ce),
      .coupler_control_word_in(ctl),
      .data_output_word_in(dout),
      .xfer_word_in(xw),
      .xfer_valid_in(xv),
      .kb_pins_in(kb_pins),
      .keyboard_status_word_out(status),
      .kb_lamp_01_out(lamp01),
      .kb_lamp_23_out(lamp23),
      .term_mode_out(tm),
      .terminate_out(term)
   );

   kb_model i_kb (
      .pins_out(kb_pins)
   );

   always #4 mclk_in = ~mclk_in;

   // Whole run needs under a hundred cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [WORD_W-1:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : step

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_lamps();
      ctl = 16'h0008; dout = 16'hA5C3; step(1);
      ctl = 16'h0408; step(1);
      check("lamp01", lamp01, 16'hA5C3);
      dout = 16'h1111; step(1);
      check("lamp01 held", lamp01, 16'hA5C3);
      ctl = 16'h0008; dout = 16'h5A3C; step(1);
      ctl = 16'h0208; step(1);
      check("lamp23", lamp23, 16'h5A3C);
      check("lamp01 kept", lamp01, 16'hA5C3);
      ctl = 16'h0000; step(1);
      ctl = 16'h0400; dout = 16'h1234; step(2);
      check("lamp01 ungated", lamp01, 16'hA5C3);
      ctl = 16'h0000; step(1);
   endtask : t_lamps

   task automatic t_status();
      kb_pins_type v [NUM_KB] = '{14'h207E, 14'h3FEF, 14'h3FDF, 14'h0ABF};
      // Keyboard 2 holds repeat with idle key data; the host repeats the last character
      for (int k = 0; k < NUM_KB; k++) begin
         i_kb.set_pins(k, v[k]);
      end
      step(3);
      for (int k = 0; k < NUM_KB; k++) begin
         ctl = 16'(k) << 11; step(2);
         check("status", status, {v[k], 2'b00});
      end
      ctl = 16'h2800; step(2);
      check("status unfitted", status, STATUS_IDLE);
      ctl = 16'h0000; step(1);
   endtask : t_status

   task automatic hit(input string name, input logic [WORD_W-1:0] w, input logic exp);
      xw = w; xv = 1'b1; step(1);
      xv = 1'b0;
      check(name, {15'h0, term}, {15'h0, exp});
      step(1);
   endtask : hit

   task automatic t_term();
      for (int b = 0; b < 3; b++) begin
         ctl = 16'h0040 << b; step(2);
         check("term_mode", 16'(tm), 16'(3'h1 << b));
      end
      ctl = 16'h0040; dout = 16'h4141; step(2);
      hit("char hit", 16'h0041, 1'b1);
      hit("char miss", 16'h0042, 1'b0);
      ctl = 16'h0044; step(1);
      hit("lockout", 16'h0041, 1'b0);
      ctl = 16'h0100; dout = 16'h1C1C; step(2);
      hit("double other", 16'h1F00, 1'b1);
      hit("double same", 16'h001C, 1'b1);
      hit("double miss", 16'h0041, 1'b0);
      ctl = 16'h0080; dout = 16'h0100; step(2);
      hit("bit hit", 16'h0300, 1'b1);
      hit("bit miss", 16'h0200, 1'b0);
      ctl = 16'h0000; step(1);
   endtask : t_term

   // Enable low must hold off a strobe until it returns, then a mid-run reset
   task automatic t_freeze();
      ce = 1'b0; ctl = 16'h0008; dout = 16'h7777; step(1);
      ctl = 16'h0408; step(2);
      check("lamp01 frozen", lamp01, 16'hA5C3);
      ce = 1'b1; step(1);
      check("lamp01 thawed", lamp01, 16'h7777);
      ctl = 16'h0000; step(1);
      reset_in = 1'b1; step(1);
      reset_in = 1'b0; step(1);
      check("lamp01 reset", lamp01, LAMP_RESET);
      check("status reset", status, STATUS_RESET);
   endtask : t_freeze

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk_in);
      #1;
      reset_in = 1'b0;
      step(1);
      check("lamp reset", lamp01, LAMP_RESET);
      t_lamps();
      t_status();
      t_term();
      t_freeze();
      summarize();
   end

endmodule : tb_display_coupler_keyboard_channels

`default_nettype wire
